//--- hdl/sled_pkg.sv
// package: constants and carrier types for the status led controller
package sled_pkg;
    // blink timing
    localparam int          BLINK_HALF_MS  = 250;
    localparam int          CLK_MHZ        = 250;
    localparam int          BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;
    // error queue depth
    localparam int          ERRQ_DEPTH     = 8;
    // led colour codes {red, green}
    localparam logic [1:0]  COLOUR_OFF     = 2'h0;
    localparam logic [1:0]  COLOUR_GREEN   = 2'h1;
    localparam logic [1:0]  COLOUR_RED     = 2'h2;
    localparam logic [1:0]  COLOUR_AMBER   = 2'h3;
    // error codes returned by the error query
    localparam logic [7:0]  ERR_CODE_NONE  = 8'h00;
    localparam logic [7:0]  ERR_CODE_BUSY  = 8'h01;
    localparam logic [7:0]  ERR_CODE_FATAL = 8'hff;

    // event flags from the instrument controller
    typedef struct packed {
        logic       comm_active;
        logic       zero_active;
        logic       cmd_pulse;
        logic       err_push;
        logic [7:0] err_code;
        logic       err_query;
        logic       fatal;
    } sled_evt_t;

    // indication selected by priority
    typedef enum logic [3:0] {
        IND_IDLE  = 4'b0001,
        IND_GREEN = 4'b0010,
        IND_AMBER = 4'b0100,
        IND_RED   = 4'b1000
    } sled_ind_t;
endpackage

//--- hdl/sled_blink.sv
// blink divider: toggles a phase after a programmable number of cycles
`timescale 1ns/1ps
module sled_blink
    import sled_pkg::*;
#(
    parameter int HALF_CYC = BLINK_HALF_CYC
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // blink phase
    output logic      phase
);
    localparam int CW = $clog2(HALF_CYC + 1);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          phase_q;
    logic          phase_d;

    // next count and phase
    always_comb begin
        cnt_d   = cnt_q + 1'b1;
        phase_d = phase_q;
        if (cnt_q == CW'(HALF_CYC - 1)) begin
            cnt_d   = '0;
            phase_d = ~phase_q;
        end
    end

    // registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q   <= '0;
            phase_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;
endmodule

//--- hdl/sled_top.sv
// top: status led controller with error queue and priority selection
// Function
// R1: green blinks while the device is communicating with the host.
// R2: a fatal hardware, system or self-test error blinks red as the top indication.
// R3: while fatal, every other indication is suppressed.
// R4: the fatal error message is returned by the error query.
// R5: a queued non-fatal error lights steady red.
// R6: reading the queued errors by error query clears steady red.
// R7: amber is lit while zeroing is in progress.
// R8: a command during zeroing records an error and turns the led steady red.
// R9: the host should read queued errors promptly.
// R10: priority is fatal blink, steady red, amber, then green blink.
`timescale 1ns/1ps
module sled_top
    import sled_pkg::*;
#(
    parameter int BLINK_CYC = BLINK_HALF_CYC,
    parameter int QDEPTH    = ERRQ_DEPTH
) (
    // clock and reset
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    // controller events
    input  wire sled_evt_t  EVT,
    // led drive
    output logic            LED_RED,
    output logic            LED_GREEN,
    // error query answer
    output logic            ERR_VALID,
    output logic [7:0]      ERR_DATA,
    output logic            ERR_PENDING
);
    localparam int QW = $clog2(QDEPTH + 1);
    localparam int AW = $clog2(QDEPTH);

    logic             phase;
    logic [7:0]       mem_q [QDEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [QW-1:0]    cnt_q, cnt_d;
    logic             fatal_q, fatal_d;
    logic             push;
    logic [7:0]       push_code;
    logic             pop;
    logic             vld_d;
    logic [7:0]       data_d;
    sled_ind_t        ind;
    logic             red_d, green_d;

    // blink phase source
    sled_blink #(
        .HALF_CYC (BLINK_CYC)
    ) u_blink (
        .clk   (CORE_CLK),
        .rst   (RST),
        .phase (phase)
    );

    // error push: explicit errors and commands during zeroing
    always_comb begin
        push      = 1'b0;
        push_code = ERR_CODE_NONE;
        if (EVT.err_push) begin
            push      = 1'b1;
            push_code = EVT.err_code;
        end else if (EVT.cmd_pulse && EVT.zero_active) begin // [R8]
            push      = 1'b1;
            push_code = ERR_CODE_BUSY;
        end
    end

    // error queue pointers, fatal latch and query answer
    always_comb begin
        wr_d    = wr_q;
        rd_d    = rd_q;
        cnt_d   = cnt_q;
        fatal_d = fatal_q | EVT.fatal; // fatal sticks until reset [R2]
        pop     = EVT.err_query && (cnt_q != '0) && !fatal_q;
        vld_d   = EVT.err_query;
        data_d  = ERR_CODE_NONE;
        if (EVT.err_query) begin
            if (fatal_q) begin
                data_d = ERR_CODE_FATAL; // fatal message via query [R4]
            end else if (cnt_q != '0) begin
                data_d = mem_q[rd_q];
            end
        end
        if (pop) begin
            rd_d = (rd_q == AW'(QDEPTH - 1)) ? '0 : rd_q + 1'b1; // read clears [R6]
        end
        if (push && cnt_q != QW'(QDEPTH) || push && pop) begin
            wr_d = (wr_q == AW'(QDEPTH - 1)) ? '0 : wr_q + 1'b1; // queue error [R5]
        end
        if ((push && cnt_q != QW'(QDEPTH) || push && pop) && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    // priority selection of the indication
    always_comb begin
        ind = IND_IDLE;
        if (cnt_q != '0) begin
            ind = IND_RED; // [R5] [R10]
        end else if (EVT.zero_active) begin
            ind = IND_AMBER; // [R7]
        end else if (EVT.comm_active) begin
            ind = IND_GREEN; // [R1]
        end
        red_d   = 1'b0;
        green_d = 1'b0;
        if (fatal_q) begin
            red_d = phase; // overrides all else [R2] [R3] [R10]
        end else begin
            case (ind)
                IND_RED: begin
                    red_d = 1'b1;
                end
                IND_AMBER: begin
                    red_d   = 1'b1;
                    green_d = 1'b1;
                end
                IND_GREEN: begin
                    green_d = phase;
                end
                default: begin
                    red_d   = 1'b0;
                    green_d = 1'b0;
                end
            endcase
        end
    end

    // queue storage
    always_ff @(posedge CORE_CLK) begin
        if (push && (cnt_q != QW'(QDEPTH) || pop)) begin
            mem_q[wr_q] <= push_code;
        end
    end

    // state and output registers
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wr_q        <= '0;
            rd_q        <= '0;
            cnt_q       <= '0;
            fatal_q     <= 1'b0;
            LED_RED     <= 1'b0;
            LED_GREEN   <= 1'b0;
            ERR_VALID   <= 1'b0;
            ERR_DATA    <= ERR_CODE_NONE;
            ERR_PENDING <= 1'b0;
        end else begin
            wr_q        <= wr_d;
            rd_q        <= rd_d;
            cnt_q       <= cnt_d;
            fatal_q     <= fatal_d;
            LED_RED     <= red_d;
            LED_GREEN   <= green_d;
            ERR_VALID   <= vld_d;
            ERR_DATA    <= data_d;
            ERR_PENDING <= (cnt_d != '0) || fatal_d;
        end
    end

    // checks
    a_fatal_no_green: assert property (@(posedge CORE_CLK) disable iff (RST) // [R3]
        fatal_q |=> !LED_GREEN) else $error("green shown during fatal");
    a_fatal_query: assert property (@(posedge CORE_CLK) disable iff (RST) // [R4]
        fatal_q && EVT.err_query |=> ERR_VALID && ERR_DATA == ERR_CODE_FATAL)
        else $error("fatal message not returned");
    a_red_steady: assert property (@(posedge CORE_CLK) disable iff (RST) // [R5]
        !fatal_q && cnt_q != '0 |=> LED_RED && !LED_GREEN)
        else $error("queued error not steady red");
    a_query_clears: assert property (@(posedge CORE_CLK) disable iff (RST) // [R6]
        !fatal_q && cnt_q == QW'(1) && EVT.err_query && !push |=> cnt_q == '0)
        else $error("query did not clear error");
    a_amber_zero: assert property (@(posedge CORE_CLK) disable iff (RST) // [R7]
        !fatal_q && cnt_q == '0 && EVT.zero_active |=> LED_RED && LED_GREEN)
        else $error("amber missing while zeroing");
    // a fatal in the same cycle would turn the red steady into a blink
    a_busy_error: assert property (@(posedge CORE_CLK) disable iff (RST) // [R8]
        !fatal_q && !EVT.fatal && EVT.cmd_pulse && EVT.zero_active && cnt_q == '0
        |=> ##1 LED_RED && !LED_GREEN) else $error("command in zeroing not red");
    a_green_blink: assert property (@(posedge CORE_CLK) disable iff (RST) // [R1] [R10]
        !fatal_q && cnt_q == '0 && !EVT.zero_active && EVT.comm_active
        |=> LED_GREEN == $past(phase) && !LED_RED) else $error("green blink wrong");
    a_fatal_blink: assert property (@(posedge CORE_CLK) disable iff (RST) // [R2]
        EVT.fatal |=> ##1 LED_RED == $past(phase)) else $error("fatal not blinking red");
    c_fatal: cover property (@(posedge CORE_CLK) disable iff (RST) EVT.fatal);
    c_busy: cover property (@(posedge CORE_CLK) disable iff (RST) EVT.cmd_pulse && EVT.zero_active);
    c_clear: cover property (@(posedge CORE_CLK) disable iff (RST) pop ##1 cnt_q == '0);
endmodule

//--- bench/sled_host_model.sv
// host model: takes error query answers as the host would
`timescale 1ns/1ps
module sled_host_model
    import sled_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // error query answer
    input  wire logic       valid,
    input  wire logic [7:0] data,
    // captured answer
    output logic [7:0]      last_q,
    output logic [7:0]      reads_q
);
    logic [7:0] last_d;
    logic [7:0] reads_d;

    // keep the newest answer and count reads
    always_comb begin
        last_d  = last_q;
        reads_d = reads_q;
        if (valid) begin // takes every query answer as it arrives
            last_d  = data;
            reads_d = reads_q + 8'h01;
        end
    end

    // register host state
    always_ff @(posedge clk) begin
        if (rst) begin
            last_q  <= 8'h00;
            reads_q <= 8'h00;
        end else begin
            last_q  <= last_d;
            reads_q <= reads_d;
        end
    end
endmodule

//--- bench/tb_top.sv
// testbench: led indication scenarios for the status led controller
`timescale 1ns/1ps
module tb_top;
    import sled_pkg::*;
    logic       core_clk;
    logic       rst;
    sled_evt_t  ev;
    logic       led_red;
    logic       led_green;
    logic       err_valid;
    logic       err_pending;
    logic [7:0] err_data;
    logic [7:0] host_last;
    logic [7:0] host_reads;
    logic [3:0] seen;
    int         err_count;
    int         checked;
    int         cycles;

    sled_top #(.BLINK_CYC(4), .QDEPTH(8)) DUT (
        .CORE_CLK(core_clk), .RST(rst), .EVT(ev), .LED_RED(led_red),
        .LED_GREEN(led_green), .ERR_VALID(err_valid), .ERR_DATA(err_data),
        .ERR_PENDING(err_pending));

    sled_host_model host (.clk(core_clk), .rst(rst), .valid(err_valid),
        .data(err_data), .last_q(host_last), .reads_q(host_reads));

    // 250 mhz clock
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // collect {red hi, red lo, green hi, green lo} over n cycles
    task scan(input int n);
        seen = 4'h0;
        repeat (n) begin
            @(negedge core_clk);
            seen = seen | {led_red, ~led_red, led_green, ~led_green};
        end
    endtask

    // one error query, then the host's copy of the answer
    task query(input logic [7:0] exp);
        cyc(1);
        ev.err_query <= 1'b1;
        cyc(1);
        ev.err_query <= 1'b0;
        @(negedge core_clk);
        chk(err_valid, 8'h01);
        @(negedge core_clk);
        chk(host_last, exp);
    endtask

    task push(input logic [7:0] code);
        ev.err_push <= 1'b1;
        ev.err_code <= code;
        cyc(1);
    endtask

    task give_verdict;
        $display("err_count %0d checked %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // bound on run length
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            err_count++;
            give_verdict;
        end
    end

    // main sequence
    initial begin
        rst = 1'b1;
        ev = '0;
        cyc(2);
        rst <= 1'b0;
        // traffic blinks green
        ev.comm_active <= 1'b1;
        scan(20);
        chk(seen, 4'h7);
        // zeroing wins over traffic
        cyc(1);
        ev.zero_active <= 1'b1;
        cyc(3);
        scan(10);
        chk(seen, 4'ha);
        // command during zeroing turns steady red
        cyc(1);
        ev.cmd_pulse <= 1'b1;
        cyc(1);
        ev.cmd_pulse <= 1'b0;
        cyc(4);
        scan(8);
        chk(seen, 4'h9);
        chk(err_pending, 8'h01);
        query(ERR_CODE_BUSY);
        cyc(1);
        ev.zero_active <= 1'b0;
        cyc(4);
        scan(20);
        chk(seen, 4'h7);
        // two queued errors back to back, read oldest first
        cyc(1);
        push(8'h05);
        push(8'h5a);
        ev.err_push <= 1'b0;
        cyc(3);
        scan(8);
        chk(seen, 4'h9);
        query(8'h05);
        scan(4);
        chk(seen, 4'h9);
        query(8'h5a);
        cyc(3);
        scan(12);
        chk(seen, 4'h7);
        // query on an empty queue answers with no error
        query(ERR_CODE_NONE);
        // fatal overrides zeroing, queued red and traffic
        cyc(1);
        ev.zero_active <= 1'b1;
        push(8'h33);
        ev.err_push <= 1'b0;
        ev.fatal <= 1'b1;
        cyc(1);
        ev.fatal <= 1'b0;
        cyc(3);
        scan(20);
        chk(seen, 4'hd);
        query(ERR_CODE_FATAL);
        chk(err_pending, 8'h01);
        chk(host_reads, 8'h05);
        give_verdict;
    end
endmodule
